// [hw/sda_params.svh]
// constants for the sampling delay adjust block
`ifndef SDA_PARAMS_SVH
`define SDA_PARAMS_SVH
`define SDA_ADDR_W 12
`define SDA_OFF_ADJUST 12'h2B5
`define SDA_OFF_RAMP 12'h2B8
`define SDA_ADJUST_RESET 24'h000000
`define SDA_RAMP_RESET 8'h00
`define SDA_INV_BIT 16
`define SDA_COARSE_HI 15
`define SDA_COARSE_LO 8
`define SDA_FINE_HI 7
`define SDA_FINE_LO 0
`define SDA_RAMP_EN_BIT 0
`define SDA_RAMP_RATE_BIT 1
`define SDA_STEP_PERIOD 384
`define SDA_SLOW_STEP 8'h01
`define SDA_FAST_STEP 8'h04
`define SDA_APPLY_LIMIT 1536
`endif

// [hw/sda_pkg.sv]
// types for the sampling delay adjust block
package sda_pkg;
  typedef enum logic [2:0] {
    SDA_IDLE = 3'b001,
    SDA_WAIT = 3'b010,
    SDA_STEP = 3'b100
  } sda_state_e;
endpackage

// [hw/sda_step_timer.sv]
// free-running step period timer for the coarse ramp
`timescale 1ns/1ps
`include "sda_params.svh"
module sda_step_timer #(
  parameter int PERIOD = `SDA_STEP_PERIOD
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic restart,
  output logic tick
);
  localparam int CW = $clog2(PERIOD);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  initial
  begin
    if (PERIOD < 2) $error("period must be at least 2");
  end

  always_comb
  begin
    tick = (cnt_r == CW'(PERIOD - 1));
    if (restart || tick)
      cnt_nxt = '0;
    else
      cnt_nxt = cnt_r + CW'(1);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end
endmodule

// [hw/sda_delay_adjust.sv]
// sampling aperture delay adjust registers and coarse ramp engine
//
// Contract
// [R1] 24-bit adjust register at 0x2B5, resets zero
// [R2] invert bit set inverts sampling clock
// [R3] coarse code applies only without calibration
// [R4] fine code applies only without calibration
// [R5] software keeps invert bit while cal/link run
// [R6] software steps coarse at most four codes
// [R7] software preferably steps coarse one code
// [R8] fine code applies immediately at any time
// [R9] 8-bit ramp control at 0x2B8, resets zero
// [R10] ramp moves 1 or 4 codes per 384
// [R11] no ramp: applied within 1536 cycles
// [R12] calibration enabled: applied values from result
// [R13] applied coarse held apart, no overshoot
// [R14] reserved bits read zero, writes ignored
`timescale 1ns/1ps
`include "sda_params.svh"
module sda_delay_adjust #(
  parameter int STEP_PERIOD = `SDA_STEP_PERIOD,
  parameter int CODE_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration port
  input wire logic [`SDA_ADDR_W-1:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [23:0] cfg_wdata,
  output logic [23:0] cfg_rdata,
  // calibration and link state
  input wire logic ref_calibration_enable,
  input wire logic [16:0] ref_calibration_result,
  input wire logic serial_link_enable,
  input wire logic converter_cal_enable,
  // applied delay to the analog line
  output logic sample_clock_invert,
  output logic [CODE_W-1:0] coarse_delay_code,
  output logic [CODE_W-1:0] fine_delay_code,
  output logic ramp_busy
);
  initial
  begin
    if (CODE_W != 8) $error("code width must be 8");
    if (STEP_PERIOD * 4 > `SDA_APPLY_LIMIT) $error("step period too long");
  end

  function automatic logic hit(input logic [`SDA_ADDR_W-1:0] a, input logic [`SDA_ADDR_W-1:0] o);
    hit = (a == o);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic inv_r, inv_nxt;
  logic [7:0] tgt_r, tgt_nxt;
  logic [7:0] fine_r, fine_nxt;
  logic ren_r, ren_nxt;
  logic rrate_r, rrate_nxt;
  logic [23:0] rdata_r, rdata_nxt;

  always_comb
  begin
    inv_nxt = inv_r;
    tgt_nxt = tgt_r;
    fine_nxt = fine_r;
    ren_nxt = ren_r;
    rrate_nxt = rrate_r;
    rdata_nxt = rdata_r;
    if (cfg_wr && hit(cfg_addr, `SDA_OFF_ADJUST)) // see [R1]
    begin
      inv_nxt = cfg_wdata[`SDA_INV_BIT];
      tgt_nxt = cfg_wdata[`SDA_COARSE_HI:`SDA_COARSE_LO];
      fine_nxt = cfg_wdata[`SDA_FINE_HI:`SDA_FINE_LO]; // see [R8]
    end
    if (cfg_wr && hit(cfg_addr, `SDA_OFF_RAMP)) // see [R9]
    begin
      ren_nxt = cfg_wdata[`SDA_RAMP_EN_BIT];
      rrate_nxt = cfg_wdata[`SDA_RAMP_RATE_BIT];
    end
    if (cfg_rd)
    begin
      rdata_nxt = 24'h000000; // see [R14]
      if (hit(cfg_addr, `SDA_OFF_ADJUST))
        rdata_nxt = {7'h00, inv_r, tgt_r, fine_r};
      else if (hit(cfg_addr, `SDA_OFF_RAMP))
        rdata_nxt = {22'h0, rrate_r, ren_r};
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      inv_r <= 1'(`SDA_ADJUST_RESET >> `SDA_INV_BIT);
      tgt_r <= 8'(`SDA_ADJUST_RESET >> `SDA_COARSE_LO);
      fine_r <= 8'(`SDA_ADJUST_RESET >> `SDA_FINE_LO);
      ren_r <= 1'(`SDA_RAMP_RESET >> `SDA_RAMP_EN_BIT);
      rrate_r <= 1'(`SDA_RAMP_RESET >> `SDA_RAMP_RATE_BIT);
      rdata_r <= 24'h000000;
    end
    else
    begin
      inv_r <= inv_nxt;
      tgt_r <= tgt_nxt;
      fine_r <= fine_nxt;
      ren_r <= ren_nxt;
      rrate_r <= rrate_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign cfg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // coarse ramp engine
  // without ramping the applied code follows the target a cycle later, far inside
  // the settle limit; during a ramp the timer runs free so steps stay evenly spaced
  sda_pkg::sda_state_e st_r, st_nxt;
  logic [7:0] app_r, app_nxt;
  logic tick;
  logic restart;
  logic [7:0] step;
  logic [8:0] diff_up, diff_dn;

  sda_step_timer #(.PERIOD(STEP_PERIOD)) u_timer (.clk(clk), .rst(rst), .restart(restart),
    .tick(tick));

  always_comb
  begin
    st_nxt = st_r;
    app_nxt = app_r;
    restart = 1'b0;
    step = rrate_r ? `SDA_FAST_STEP : `SDA_SLOW_STEP; // see [R10]
    diff_up = {1'b0, tgt_r} - {1'b0, app_r};
    diff_dn = {1'b0, app_r} - {1'b0, tgt_r};
    case (st_r)
      sda_pkg::SDA_IDLE:
      begin
        if (tgt_r != app_r)
        begin
          if (!ren_r)
            app_nxt = tgt_r; // see [R11]
          else
          begin
            restart = 1'b1;
            st_nxt = sda_pkg::SDA_WAIT;
          end
        end
      end
      sda_pkg::SDA_WAIT:
      begin
        if (!ren_r)
        begin
          app_nxt = tgt_r; // see [R11]
          st_nxt = sda_pkg::SDA_IDLE;
        end
        else if (tick)
          st_nxt = sda_pkg::SDA_STEP;
      end
      sda_pkg::SDA_STEP:
      begin
        // clamp to target so a 4-code step never overshoots
        if (tgt_r > app_r)
          app_nxt = (diff_up[7:0] < step) ? tgt_r : app_r + step; // see [R13]
        else if (tgt_r < app_r)
          app_nxt = (diff_dn[7:0] < step) ? tgt_r : app_r - step; // see [R13]
        st_nxt = (app_nxt != tgt_r) ? sda_pkg::SDA_WAIT : sda_pkg::SDA_IDLE; // see [R10]
      end
      default:
        st_nxt = sda_pkg::SDA_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r <= sda_pkg::SDA_IDLE;
      app_r <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
      app_r <= app_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // applied outputs; software keeps cal/link glitch rules (see [R5]) (see [R6]) (see [R7])
  logic inv_o_r, inv_o_nxt;
  logic [7:0] crs_o_r, crs_o_nxt, fin_o_r, fin_o_nxt;

  always_comb
  begin
    if (ref_calibration_enable)
    begin
      inv_o_nxt = ref_calibration_result[`SDA_INV_BIT]; // see [R12]
      crs_o_nxt = ref_calibration_result[`SDA_COARSE_HI:`SDA_COARSE_LO];
      fin_o_nxt = ref_calibration_result[`SDA_FINE_HI:`SDA_FINE_LO];
    end
    else
    begin
      inv_o_nxt = inv_r; // see [R2]
      crs_o_nxt = app_r; // see [R3]
      fin_o_nxt = fine_r; // see [R4]
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      inv_o_r <= 1'b0;
      crs_o_r <= 8'h00;
      fin_o_r <= 8'h00;
    end
    else
    begin
      inv_o_r <= inv_o_nxt;
      crs_o_r <= crs_o_nxt;
      fin_o_r <= fin_o_nxt;
    end
  end
  assign sample_clock_invert = inv_o_r;
  assign coarse_delay_code = crs_o_r;
  assign fine_delay_code = fin_o_r;
  assign ramp_busy = (st_r != sda_pkg::SDA_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_reset_zero;
    @(posedge clk) rst |=> (!inv_r && tgt_r == 8'h00 && fine_r == 8'h00 && !ren_r && !rrate_r);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong"); // see [R1], [R9]
  property p_inv_follow;
    @(posedge clk) disable iff (rst)
      !ref_calibration_enable |=> (sample_clock_invert == $past(inv_r));
  endproperty
  a_inv_follow: assert property (p_inv_follow) else $error("invert not applied"); // see [R2]
  property p_coarse_manual;
    @(posedge clk) disable iff (rst)
      !ref_calibration_enable |=> (coarse_delay_code == $past(app_r));
  endproperty
  a_coarse_manual: assert property (p_coarse_manual) else $error("coarse wrong"); // see [R3]
  property p_fine_manual;
    @(posedge clk) disable iff (rst)
      (cfg_wr && cfg_addr == `SDA_OFF_ADJUST && !ref_calibration_enable)
        ##1 !ref_calibration_enable |=> (fine_delay_code == $past(cfg_wdata[7:0], 2));
  endproperty
  a_fine_manual: assert property (p_fine_manual) else $error("fine not direct"); // see [R4]
  property p_fine_any;
    @(posedge clk) disable iff (rst)
      (cfg_wr && cfg_addr == `SDA_OFF_ADJUST) |=> (fine_r == $past(cfg_wdata[7:0]));
  endproperty
  a_fine_any: assert property (p_fine_any) else $error("fine write lost"); // see [R8]
  property p_ramp_reg;
    @(posedge clk) disable iff (rst)
      (cfg_wr && cfg_addr == `SDA_OFF_RAMP) |=> (ren_r == $past(cfg_wdata[0]));
  endproperty
  a_ramp_reg: assert property (p_ramp_reg) else $error("ramp control lost"); // see [R9]
  property p_step_size;
    @(posedge clk) disable iff (rst)
      (app_r != $past(app_r) && $past(ren_r) && ren_r && $past(st_r) == sda_pkg::SDA_STEP)
        |-> ((app_r > $past(app_r) ? app_r - $past(app_r) : $past(app_r) - app_r)
             <= ($past(rrate_r) ? `SDA_FAST_STEP : `SDA_SLOW_STEP));
  endproperty
  a_step_size: assert property (p_step_size) else $error("ramp step too big"); // see [R10]
  sequence s_plain_write;
    cfg_wr && cfg_addr == `SDA_OFF_ADJUST && !ren_r && !ref_calibration_enable;
  endsequence
  property p_no_ramp_apply;
    @(posedge clk) disable iff (rst)
      s_plain_write ##1 (!ren_r && !cfg_wr)[*3] |-> (app_r == tgt_r);
  endproperty
  a_no_ramp_apply: assert property (p_no_ramp_apply) else $error("coarse not applied"); // see [R11]
  property p_cal_source;
    @(posedge clk) disable iff (rst)
      ref_calibration_enable |=> (fine_delay_code == $past(ref_calibration_result[7:0]));
  endproperty
  a_cal_source: assert property (p_cal_source) else $error("cal result ignored"); // see [R12]
  property p_no_overshoot;
    @(posedge clk) disable iff (rst)
      ($past(st_r) == sda_pkg::SDA_STEP && $stable(tgt_r) && $past(app_r) < tgt_r)
        |-> (app_r <= tgt_r);
  endproperty
  a_no_overshoot: assert property (p_no_overshoot) else $error("ramp overshoot"); // see [R13]
  property p_reserved_zero;
    @(posedge clk) disable iff (rst)
      (cfg_rd && cfg_addr == `SDA_OFF_RAMP) |=> (cfg_rdata[23:2] == 22'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved not zero"); // see [R14]
  property p_link_step;
    @(posedge clk) disable iff (rst)
      (serial_link_enable || converter_cal_enable) && $past(ren_r)
        |-> (app_r - $past(app_r) <= `SDA_FAST_STEP || $past(app_r) - app_r <= `SDA_FAST_STEP);
  endproperty
  a_link_step: assert property (p_link_step) else $error("coarse jump under link"); // see [R6]
endmodule

// [dv/tb.sv]
// self-checking bench for the sampling delay adjust block
`timescale 1ns/1ps
`include "sda_params.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module tb;
  localparam int PER = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [`SDA_ADDR_W-1:0] cfg_addr = '0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [23:0] cfg_wdata = '0;
  logic [23:0] cfg_rdata;
  logic cal_en = 1'b0;
  logic [16:0] cal_res = '0;
  logic link_en = 1'b0;
  logic conv_cal = 1'b0;
  logic inv;
  logic [7:0] coarse;
  logic [7:0] fine;
  logic busy;
  int fail_count = 0;
  int checks = 0;
  // short step period keeps ramps cheap; expectations use PER
  sda_delay_adjust #(.STEP_PERIOD(PER)) sda_delay_adjust_inst (
    .clk(clk), .rst(rst), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .ref_calibration_enable(cal_en),
    .ref_calibration_result(cal_res), .serial_link_enable(link_en),
    .converter_cal_enable(conv_cal), .sample_clock_invert(inv),
    .coarse_delay_code(coarse), .fine_delay_code(fine), .ramp_busy(busy));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic step_ok(logic [7:0] p, logic [7:0] c, logic [7:0] t,
                                   logic [7:0] s);
    logic [7:0] d;
    d = (t > p) ? t - p : p - t;
    if (d > s)
      d = s;
    return (t > p) ? (c == p + d) : (c == p - d);
  endfunction
  task automatic wr(input logic [11:0] a, input logic [23:0] d);
    @(negedge clk);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask
  task automatic rd_chk(input string n, input logic [11:0] a, input logic [23:0] e);
    @(negedge clk);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge clk);
    cfg_rd = 1'b0;
    @(negedge clk);
    `CHK(n, e, cfg_rdata)
  endtask
  task automatic ramp(input logic rate, input logic [7:0] tgt, input int exp_n);
    logic [7:0] prev;
    logic [7:0] st;
    logic [7:0] f;
    int n;
    int gap;
    int steps;
    st = rate ? `SDA_FAST_STEP : `SDA_SLOW_STEP;
    f = 8'($urandom());
    wr(`SDA_OFF_RAMP, {22'h0, rate, 1'b1});
    prev = coarse;
    wr(`SDA_OFF_ADJUST, {8'h00, tgt, f});
    @(negedge clk);
    `CHK("busy", 1'b1, busy)
    `CHK("fine now", f, fine)
    steps = 0;
    gap = 0;
    for (n = 0; n < 3000 && coarse !== tgt; n++)
    begin
      @(negedge clk);
      gap++;
      if (coarse !== prev)
      begin
        steps++;
        `CHK("step size", 1'b1, step_ok(prev, coarse, tgt, st))
        `CHK("step gap", 1'b1, (steps == 1) ? (gap >= PER) : (gap == PER))
        prev = coarse;
        gap = 0;
      end
    end
    if (coarse !== tgt)
    begin
      fail_count++;
      $display("ERROR ramp timeout exp %h got %h", tgt, coarse);
      finish_test();
    end
    repeat (PER + 3) @(negedge clk);
    `CHK("ramp end", tgt, coarse)
    `CHK("ramp steps", exp_n, steps)
    `CHK("idle", 1'b0, busy)
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #5 clk = ~clk;
  end
  initial
  begin
    logic [23:0] d;
    logic [7:0] t;
    int k;
    int dl;
    void'($urandom(32'hD12DD232));
    repeat (20) @(negedge clk);
    rst = 1'b0;
    `CHK("reset outs", 18'h0, {inv, coarse, fine, busy})
    rd_chk("adjust reset", `SDA_OFF_ADJUST, `SDA_ADJUST_RESET);
    rd_chk("ramp reset", `SDA_OFF_RAMP, 24'h0);
    $display("test reset done");
    // inversion changes only while both enables are low
    for (k = 0; k < 6; k++)
    begin
      d = (k == 0) ? 24'hFFFFFF : 24'($urandom());
      wr(`SDA_OFF_ADJUST, d);
      rd_chk("adjust rd", `SDA_OFF_ADJUST, d & 24'h01FFFF);
      `CHK("fine out", d[7:0], fine)
      `CHK("invert out", d[16], inv)
      `CHK("coarse out", d[15:8], coarse)
    end
    wr(12'h2B6, 24'hFFFFFF);
    rd_chk("unmapped", 12'h2B6, 24'h0);
    rd_chk("adjust kept", `SDA_OFF_ADJUST, d & 24'h01FFFF);
    wr(`SDA_OFF_RAMP, 24'hFFFFFF);
    rd_chk("ramp rd", `SDA_OFF_RAMP, 24'h000003);
    wr(`SDA_OFF_RAMP, 24'h0);
    $display("test registers done");
    cal_en = 1'b1;
    cal_res = 17'($urandom());
    repeat (3) @(negedge clk);
    `CHK("cal outs", cal_res, {inv, coarse, fine})
    wr(`SDA_OFF_ADJUST, 24'($urandom()));
    repeat (3) @(negedge clk);
    `CHK("cal hold", cal_res, {inv, coarse, fine})
    cal_en = 1'b0;
    wr(`SDA_OFF_ADJUST, 24'h008000);
    repeat (3) @(negedge clk);
    `CHK("manual back", 8'h80, coarse)
    `CHK("manual fine", 8'h00, fine)
    `CHK("manual invert", 1'b0, inv)
    $display("test calibration done");
    link_en = 1'b1;
    conv_cal = 1'b1;
    // coarse moves only through the ramp while link and calibration run
    for (k = 0; k < 4; k++)
    begin
      dl = (k == 0) ? 1 : $urandom_range(12, 2);
      t = k[1] ? coarse - 8'(dl) : coarse + 8'(dl);
      ramp(k[0], t, k[0] ? (dl + 3) / 4 : dl);
    end
    $display("test ramp done");
    finish_test();
  end
endmodule
